// file: include/trx_pkg.sv
// Constants for the receive link configuration bank.
// Assumes a 16-bit host word port with word addresses.
package trx_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_LINKS   = 16;
    localparam int ADDR_W      = 12;
    localparam int DATA_W      = 16;
    localparam int BUF_WORDS   = 1024;
    localparam int BUF_AW      = 10;
    localparam int BLOCK_WORDS = 32;
    localparam int BLOCK_AW    = 5;

    // ==========================================================
    // Register offsets (word addresses)
    localparam logic [11:0] CTRL_BASE    = 12'h0700;
    localparam logic [11:0] MAPL_BASE    = 12'h0710;
    localparam logic [11:0] MAPH_BASE    = 12'h0720;
    localparam logic [11:0] TUNE_ADDR    = 12'h0741;
    localparam logic [11:0] XFER_ADDR    = 12'h0742;
    localparam logic [11:0] RFLT_ADDR    = 12'h0743;
    localparam logic [11:0] BUF_BASE     = 12'h0800;
    localparam logic [11:0] LINK_STRIDE  = 12'h0040;
    localparam logic [11:0] NEW_CELL_OFS = 12'h0020;

    // ==========================================================
    // Control word fields
    localparam int CTRL_CELLSYNC_BIT = 10;
    localparam int CTRL_LOOP_BIT     = 8;
    localparam int CTRL_EN_BIT       = 7;
    localparam int CTRL_RATE_LO      = 5;
    localparam int CTRL_POL_BIT      = 1;
    localparam logic [15:0] CTRL_WR_MASK = 16'h0FFF;
    localparam logic [15:0] CTRL_RD_MASK = 16'h07FF;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] MAP_RST      = 16'h0000;
    localparam logic [7:0]  TUNE_RST     = 8'h00;

    // ==========================================================
    // Rate codes
    localparam logic [1:0] RATE_10M0 = 2'b11;
    localparam logic [1:0] RATE_5M0  = 2'b10;
    localparam logic [1:0] RATE_2M5  = 2'b01;
    localparam logic [1:0] RATE_RSVD = 2'b00;
    localparam int RATE_5M0_LAST_LINK = 12;

    // ==========================================================
    // Transfer command word
    localparam int XFER_GO_BIT   = 15;
    localparam int XFER_BUSY_BIT = 15;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b01,
        XF_COPY = 2'b10
    } trx_xfer_state_t;

endpackage : trx_pkg

// file: src/trx_word_mem.sv
// Simple dual-port word memory with registered read data.
// Assumes one clock; contents are not reset.
`timescale 1ns/10ps
module trx_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // Write port
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input  wire logic             rd_en_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    // ==========================================================
    // Storage
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rd_data_q;

    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Read data held between reads
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_q <= '0;
        end else if (rd_en_i) begin
            rd_data_q <= mem_q[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_q;

endmodule : trx_word_mem

// file: src/trx_link_bank.sv
// Receive link configuration bank with per-link receive front end.
// Assumes a host word port on clock_i and link pins asynchronous to it.
//
// What this block does
// - Loopback takes clock and data from transmit pins
// - Loopback leaves transmit running normally; the link's receive pins are ignored
// - Link enable bit turns the receive port on
// - Rate 11 is 10 Mb/s, links 0,4,8,12
// - Rate 10 is 5 Mb/s, even links to 12
// - Rate 01 is 2.5 Mb/s; 00 reserved
// - Polarity 0 samples rising, 1 samples falling
// - Cell window copied inside on transfer command
// - Two 32-word blocks per link, stride 0x40
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module trx_link_bank #(
    parameter int NUM_LINKS = trx_pkg::NUM_LINKS
) (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // Host register port
    input  wire logic [11:0]              reg_addr_i,
    input  wire logic [15:0]              reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [15:0]              reg_rdata_o,
    // Link pins
    input  wire logic [NUM_LINKS-1:0]     rx_link_clock_i,
    input  wire logic [NUM_LINKS-1:0]     rx_serial_data_in_i,
    input  wire logic [NUM_LINKS-1:0]     tx_link_clock_i,
    input  wire logic [NUM_LINKS-1:0]     tx_serial_data_i,
    // Received bits
    output logic      [NUM_LINKS-1:0]     rx_bit_o,
    output logic      [NUM_LINKS-1:0]     rx_bit_valid_o,
    // Link configuration to cell logic
    output logic      [NUM_LINKS-1:0]     link_active_o,
    output logic      [2*NUM_LINKS-1:0]   link_rate_o,
    output logic      [NUM_LINKS-1:0]     rate_fault_o,
    output logic      [NUM_LINKS-1:0]     cell_sync_en_o,
    output logic      [7:0]               cell_sync_tuning_o,
    output logic      [16*NUM_LINKS-1:0]  ts_map_low_o,
    output logic      [16*NUM_LINKS-1:0]  ts_map_high_o,
    // Internal control cell memory read
    input  wire logic                     cell_rd_en_i,
    input  wire logic [9:0]               cell_rd_addr_i,
    output logic      [15:0]              cell_rd_data_o,
    output logic                          xfer_busy_o
);

    // ==========================================================
    // Register state
    logic [15:0] ctrl_q [NUM_LINKS];
    logic [15:0] ctrl_d [NUM_LINKS];
    logic [15:0] mapl_q [NUM_LINKS];
    logic [15:0] mapl_d [NUM_LINKS];
    logic [15:0] maph_q [NUM_LINKS];
    logic [15:0] maph_d [NUM_LINKS];
    logic [7:0]  tune_q;
    logic [7:0]  tune_d;
    logic [NUM_LINKS-1:0] fault_q;
    logic [NUM_LINKS-1:0] fault_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        mem_sel_q;
    logic        mem_sel_d;

    logic        hit_ctrl;
    logic        hit_mapl;
    logic        hit_maph;
    logic        hit_buf;
    logic [3:0]  idx;

    assign idx      = reg_addr_i[3:0];
    assign hit_ctrl = reg_addr_i[11:4] == trx_pkg::CTRL_BASE[11:4];
    assign hit_mapl = reg_addr_i[11:4] == trx_pkg::MAPL_BASE[11:4];
    assign hit_maph = reg_addr_i[11:4] == trx_pkg::MAPH_BASE[11:4];
    assign hit_buf  = reg_addr_i[11:10] == trx_pkg::BUF_BASE[11:10];

    // ==========================================================
    // Transfer engine state
    trx_pkg::trx_xfer_state_t st_q;
    trx_pkg::trx_xfer_state_t st_d;
    logic [4:0]  blk_q;
    logic [4:0]  blk_d;
    logic [4:0]  word_q;
    logic [4:0]  word_d;
    logic        issued_all_q;
    logic        issued_all_d;
    logic        pend_q;
    logic        pend_d;
    logic [4:0]  pend_word_q;
    logic [4:0]  pend_word_d;

    logic        host_buf_rd;
    logic        eng_rd;
    logic [15:0] win_rd_data;

    // Host reads of the window win over the engine so the host never waits
    assign host_buf_rd = reg_rd_i && hit_buf;
    assign eng_rd      = (st_q == trx_pkg::XF_COPY) && !issued_all_q && !host_buf_rd;

    // ==========================================================
    // Rate check per link
    function automatic logic rate_bad(input logic [1:0] rate, input int link);
        logic bad;
        bad = 1'b0;
        case (rate)
            trx_pkg::RATE_10M0: bad = (link % 4) != 0;
            trx_pkg::RATE_5M0:  bad = ((link % 2) != 0) || (link > trx_pkg::RATE_5M0_LAST_LINK);
            trx_pkg::RATE_2M5:  bad = 1'b0;
            default:            bad = 1'b1;
        endcase
        return bad;
    endfunction : rate_bad

    // ==========================================================
    // Register next state
    always_comb begin
        for (int i = 0; i < NUM_LINKS; i++) begin
            ctrl_d[i]  = ctrl_q[i];
            mapl_d[i]  = mapl_q[i];
            maph_d[i]  = maph_q[i];
            fault_d[i] = rate_bad(ctrl_q[i][trx_pkg::CTRL_RATE_LO +: 2], i);
        end
        tune_d    = tune_q;
        rdata_d   = rdata_q;
        mem_sel_d = 1'b0;
        if (reg_wr_i) begin
            if (hit_ctrl) begin
                ctrl_d[idx] = reg_wdata_i & trx_pkg::CTRL_WR_MASK;
            end
            if (hit_mapl) begin
                mapl_d[idx] = reg_wdata_i;
            end
            if (hit_maph) begin
                maph_d[idx] = reg_wdata_i;
            end
            if (reg_addr_i == trx_pkg::TUNE_ADDR) begin
                tune_d = reg_wdata_i[7:0];
            end
        end
        if (reg_rd_i) begin
            rdata_d   = 16'h0000;
            mem_sel_d = hit_buf;
            if (hit_ctrl) begin
                rdata_d = ctrl_q[idx] & trx_pkg::CTRL_RD_MASK;
            end else if (hit_mapl) begin
                rdata_d = mapl_q[idx];
            end else if (hit_maph) begin
                rdata_d = maph_q[idx];
            end else if (reg_addr_i == trx_pkg::TUNE_ADDR) begin
                rdata_d = {8'h00, tune_q};
            end else if (reg_addr_i == trx_pkg::XFER_ADDR) begin
                rdata_d = {(st_q == trx_pkg::XF_COPY), 10'h000, blk_q};
            end else if (reg_addr_i == trx_pkg::RFLT_ADDR) begin
                rdata_d = 16'(fault_q);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                ctrl_q[i] <= trx_pkg::CTRL_RST;
                mapl_q[i] <= trx_pkg::MAP_RST;
                maph_q[i] <= trx_pkg::MAP_RST;
            end
            tune_q    <= trx_pkg::TUNE_RST;
            fault_q   <= '0;
            rdata_q   <= 16'h0000;
            mem_sel_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                ctrl_q[i] <= ctrl_d[i];
                mapl_q[i] <= mapl_d[i];
                maph_q[i] <= maph_d[i];
            end
            tune_q    <= tune_d;
            fault_q   <= fault_d;
            rdata_q   <= rdata_d;
            mem_sel_q <= mem_sel_d;
        end
    end

    // Window data already sits in the memory's output register
    assign reg_rdata_o = mem_sel_q ? win_rd_data : rdata_q;

    // ==========================================================
    // Transfer engine: copies one 32-word block into internal memory
    always_comb begin
        st_d         = st_q;
        blk_d        = blk_q;
        word_d       = word_q;
        issued_all_d = issued_all_q;
        pend_d       = eng_rd;
        pend_word_d  = word_q;
        case (st_q)
            trx_pkg::XF_IDLE: begin
                if (reg_wr_i && (reg_addr_i == trx_pkg::XFER_ADDR) && reg_wdata_i[trx_pkg::XFER_GO_BIT]) begin
                    st_d         = trx_pkg::XF_COPY;
                    blk_d        = reg_wdata_i[4:0];
                    word_d       = 5'h00;
                    issued_all_d = 1'b0;
                end
            end
            trx_pkg::XF_COPY: begin
                // A new command during a copy is ignored
                if (eng_rd) begin
                    word_d       = word_q + 5'h01;
                    issued_all_d = (word_q == 5'h1F);
                end
                if (pend_q && (pend_word_q == 5'h1F)) begin
                    st_d = trx_pkg::XF_IDLE;
                end
            end
            default: begin
                st_d = trx_pkg::XF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q         <= trx_pkg::XF_IDLE;
            blk_q        <= 5'h00;
            word_q       <= 5'h00;
            issued_all_q <= 1'b0;
            pend_q       <= 1'b0;
            pend_word_q  <= 5'h00;
        end else begin
            st_q         <= st_d;
            blk_q        <= blk_d;
            word_q       <= word_d;
            issued_all_q <= issued_all_d;
            pend_q       <= pend_d;
            pend_word_q  <= pend_word_d;
        end
    end

    assign xfer_busy_o = (st_q == trx_pkg::XF_COPY);

    // Block index is {link, new/old}: old cell then new cell per link
    trx_word_mem #(
        .WIDTH (16),
        .DEPTH (trx_pkg::BUF_WORDS),
        .AW    (trx_pkg::BUF_AW)
    ) u_window (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .wr_en_i   (reg_wr_i && hit_buf),
        .wr_addr_i (reg_addr_i[9:0]),
        .wr_data_i (reg_wdata_i),
        .rd_en_i   (host_buf_rd || eng_rd),
        .rd_addr_i (host_buf_rd ? reg_addr_i[9:0] : {blk_q, word_q}),
        .rd_data_o (win_rd_data)
    );

    // Limitation: host writes to a block under copy may land half-copied
    trx_word_mem #(
        .WIDTH (16),
        .DEPTH (trx_pkg::BUF_WORDS),
        .AW    (trx_pkg::BUF_AW)
    ) u_internal (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .wr_en_i   (pend_q),
        .wr_addr_i ({blk_q, pend_word_q}),
        .wr_data_i (win_rd_data),
        .rd_en_i   (cell_rd_en_i),
        .rd_addr_i (cell_rd_addr_i),
        .rd_data_o (cell_rd_data_o)
    );

    // ==========================================================
    // Link front end
    // Pins are oversampled on clock_i, so a link clock must stay well
    // below half the system rate to be seen edge by edge.
    logic [2*NUM_LINKS-1:0] ck_s1_q;
    logic [2*NUM_LINKS-1:0] ck_s2_q;
    logic [NUM_LINKS-1:0]   ck_s3_q;
    logic [2*NUM_LINKS-1:0] dt_s1_q;
    logic [2*NUM_LINKS-1:0] dt_s2_q;
    logic [NUM_LINKS-1:0] bit_q;
    logic [NUM_LINKS-1:0] bit_d;
    logic [NUM_LINKS-1:0] vld_q;
    logic [NUM_LINKS-1:0] vld_d;
    logic [NUM_LINKS-1:0] src_ck;
    logic [NUM_LINKS-1:0] src_dt;

    // Both pin sets are synchronised first, so the mux only sees settled levels
    always_comb begin
        for (int i = 0; i < NUM_LINKS; i++) begin
            src_ck[i] = ctrl_q[i][trx_pkg::CTRL_LOOP_BIT] ? ck_s2_q[NUM_LINKS+i] : ck_s2_q[i];
            src_dt[i] = ctrl_q[i][trx_pkg::CTRL_LOOP_BIT] ? dt_s2_q[NUM_LINKS+i] : dt_s2_q[i];
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_LINKS; i++) begin
            logic edge_hit;
            edge_hit = ctrl_q[i][trx_pkg::CTRL_POL_BIT] ? (!src_ck[i] && ck_s3_q[i])
                                                         : (src_ck[i] && !ck_s3_q[i]);
            vld_d[i] = edge_hit && ctrl_q[i][trx_pkg::CTRL_EN_BIT];
            bit_d[i] = vld_d[i] ? src_dt[i] : bit_q[i];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ck_s1_q <= '0;
            ck_s2_q <= '0;
            ck_s3_q <= '0;
            dt_s1_q <= '0;
            dt_s2_q <= '0;
            bit_q   <= '0;
            vld_q   <= '0;
        end else begin
            ck_s1_q <= {tx_link_clock_i, rx_link_clock_i};
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= src_ck;
            dt_s1_q <= {tx_serial_data_i, rx_serial_data_in_i};
            dt_s2_q <= dt_s1_q;
            bit_q   <= bit_d;
            vld_q   <= vld_d;
        end
    end

    assign rx_bit_o           = bit_q;
    assign rx_bit_valid_o     = vld_q;
    assign rate_fault_o       = fault_q;
    assign cell_sync_tuning_o = tune_q;

    // ==========================================================
    // Per-link configuration outputs
    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link
        assign link_active_o[g]       = ctrl_q[g][trx_pkg::CTRL_EN_BIT];
        assign link_rate_o[2*g +: 2]  = ctrl_q[g][trx_pkg::CTRL_RATE_LO +: 2];
        assign cell_sync_en_o[g]      = ctrl_q[g][trx_pkg::CTRL_CELLSYNC_BIT];
        assign ts_map_low_o[16*g +: 16]  = mapl_q[g];
        assign ts_map_high_o[16*g +: 16] = maph_q[g];
    end

endmodule : trx_link_bank

// file: verif/trx_framer_model.sv
// Behavioural framer model driving the receive and transmit link pins.
// Assumes one call of send_bit at a time; clocks stand still between bits.
`timescale 1ns/10ps
module trx_framer_model #(
    parameter int HALF_NS = 2030
) (
    // Receive pins
    output logic [15:0] rx_clk_o,
    output logic [15:0] rx_dat_o,
    // Transmit pins looped back inside the device
    output logic [15:0] tx_clk_o,
    output logic [15:0] tx_dat_o
);
    // ====================
    // Pin state, transmit pins in the upper half
    logic [31:0] clk_q = 32'h0000_0000;
    logic [31:0] dat_q = 32'h0000_0000;
    assign rx_clk_o = clk_q[15:0];
    assign rx_dat_o = dat_q[15:0];
    assign tx_clk_o = clk_q[31:16];
    assign tx_dat_o = dat_q[31:16];

    // ====================
    // One bit: data stands across both clock edges, then is inverted
    // Half period is off the system grid so the clock pins never move on a bank edge
    task automatic send_bit(input int l, input bit tx, input logic b);
        int k;
        k = l + (tx ? 16 : 0);
        dat_q[k] = b;
        #(HALF_NS);
        clk_q[k] = 1'b1;
        #(HALF_NS);
        clk_q[k] = 1'b0;
        #(HALF_NS);
        dat_q[k] = ~b;
    endtask : send_bit
endmodule : trx_framer_model

// file: verif/trx_link_bank_checker.sv
// Port checker for the receive link configuration bank.
// Assumes the bind below; the host port never stalls.
`timescale 1ns/10ps
module trx_link_bank_checker #(
    parameter int NUM_LINKS = 16
) (
    // Clock, reset and host port
    input wire logic                    clock_i,
    input wire logic                    rst_n_i,
    input wire logic [11:0]             reg_addr_i,
    input wire logic [15:0]             reg_wdata_i,
    input wire logic                    reg_wr_i,
    input wire logic                    reg_rd_i,
    input wire logic [15:0]             reg_rdata_o,
    // Link configuration
    input wire logic [NUM_LINKS-1:0]    link_active_o,
    input wire logic [2*NUM_LINKS-1:0]  link_rate_o,
    input wire logic [NUM_LINKS-1:0]    rate_fault_o,
    input wire logic [NUM_LINKS-1:0]    cell_sync_en_o,
    input wire logic [16*NUM_LINKS-1:0] ts_map_low_o,
    input wire logic [NUM_LINKS-1:0]    rx_bit_valid_o,
    input wire logic                    xfer_busy_o
);
    // ====================
    // Last access, so checks can name the link it touched
    logic [3:0]  li_q;
    logic [15:0] wd_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            li_q <= 4'h0;
            wd_q <= 16'h0000;
        end else begin
            li_q <= reg_addr_i[3:0];
            wd_q <= reg_wdata_i;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // ====================
    // Assertions
    property p_ctrl_rd; reg_rd_i && reg_addr_i[11:4] == 8'h70 |=> reg_rdata_o[15:11] == 5'h00; endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control word shows unused bits");
    property p_unmap_rd; reg_rd_i && reg_addr_i[11:4] == 8'h73 |=> reg_rdata_o == 16'h0000; endproperty
    a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
    property p_en;
        reg_wr_i && reg_addr_i[11:4] == 8'h70 |=> link_active_o[li_q] == wd_q[7] && cell_sync_en_o[li_q] == wd_q[10];
    endproperty
    a_en: assert property (p_en) else $error("enable or cell sync not applied");
    property p_rate; reg_wr_i && reg_addr_i[11:4] == 8'h70 |=> link_rate_o[2*li_q +: 2] == wd_q[6:5]; endproperty
    a_rate: assert property (p_rate) else $error("rate code not applied");
    property p_map; reg_wr_i && reg_addr_i[11:4] == 8'h71 |=> ts_map_low_o[16*li_q +: 16] == wd_q; endproperty
    a_map: assert property (p_map) else $error("low timeslot map not applied");
    property p_flt2; $changed(link_rate_o[5:4]) |=> rate_fault_o[2] == (link_rate_o[5:4] inside {2'b00, 2'b11}); endproperty
    a_flt2: assert property (p_flt2) else $error("rate fault wrong on link 2");
    property p_flt4; $changed(link_rate_o[9:8]) |=> rate_fault_o[4] == (link_rate_o[9:8] == 2'b00); endproperty
    a_flt4: assert property (p_flt4) else $error("rate fault wrong on link 4");
    property p_busy_on; reg_wr_i && reg_addr_i == 12'h742 && reg_wdata_i[15] && !xfer_busy_o |=> xfer_busy_o; endproperty
    a_busy_on: assert property (p_busy_on) else $error("transfer did not start");
    property p_busy_min; $fell(xfer_busy_o) |-> $past(xfer_busy_o, 33); endproperty
    a_busy_min: assert property (p_busy_min) else $error("transfer ended early");
    property p_busy_end; $rose(xfer_busy_o) |-> ##[33:1000] !xfer_busy_o; endproperty
    a_busy_end: assert property (p_busy_end) else $error("transfer never ended");
    property p_vld_en; rx_bit_valid_o[0] |-> link_active_o[0]; endproperty
    a_vld_en: assert property (p_vld_en) else $error("bit taken on disabled link");
    c_xfer: cover property ($rose(xfer_busy_o));
    c_pulse: cover property (rx_bit_valid_o[0]);
    c_fault: cover property ($rose(rate_fault_o[2]));
endmodule : trx_link_bank_checker

bind trx_link_bank trx_link_bank_checker #(.NUM_LINKS(NUM_LINKS)) trx_link_bank_checker_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link_active_o(link_active_o),
    .link_rate_o(link_rate_o), .rate_fault_o(rate_fault_o), .cell_sync_en_o(cell_sync_en_o),
    .ts_map_low_o(ts_map_low_o), .rx_bit_valid_o(rx_bit_valid_o), .xfer_busy_o(xfer_busy_o)
);

// file: verif/trx_link_bank_tb.sv
// Self-checking bench for the receive link configuration bank.
// Assumes the framer model owns every link pin.
`timescale 1ns/10ps
module trx_link_bank_tb;
    // ====================
    // Stimulus and observed signals
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic cell_rd_en_i = 1'b0;
    logic [9:0] cell_rd_addr_i = 10'h000;
    logic [15:0] reg_rdata_o, rx_bit_o, rx_bit_valid_o, link_active_o, rate_fault_o, cell_sync_en_o, cell_rd_data_o;
    logic [31:0] link_rate_o;
    logic [7:0] cell_sync_tuning_o;
    logic [255:0] ts_map_low_o, ts_map_high_o;
    logic xfer_busy_o;
    wire logic [15:0] rxc, rxd, txc, txd;
    int error_cnt = 0;
    int n_tests = 0;
    int pc [16];
    logic [15:0] bt, lv;
    logic [3:0] rl [9] = '{0, 4, 2, 2, 3, 14, 12, 7, 7};
    logic [1:0] rc [9] = '{3, 3, 3, 2, 2, 2, 2, 1, 0};
    logic rf [9] = '{0, 0, 1, 0, 1, 1, 0, 0, 1};

    always #50 clock_i = ~clock_i;

    trx_framer_model trx_framer_model_inst (.rx_clk_o(rxc), .rx_dat_o(rxd), .tx_clk_o(txc), .tx_dat_o(txd));
    trx_link_bank trx_link_bank_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_link_clock_i(rxc),
        .rx_serial_data_in_i(rxd), .tx_link_clock_i(txc), .tx_serial_data_i(txd), .rx_bit_o(rx_bit_o),
        .rx_bit_valid_o(rx_bit_valid_o), .link_active_o(link_active_o), .link_rate_o(link_rate_o),
        .rate_fault_o(rate_fault_o), .cell_sync_en_o(cell_sync_en_o), .cell_sync_tuning_o(cell_sync_tuning_o),
        .ts_map_low_o(ts_map_low_o), .ts_map_high_o(ts_map_high_o), .cell_rd_en_i(cell_rd_en_i),
        .cell_rd_addr_i(cell_rd_addr_i), .cell_rd_data_o(cell_rd_data_o), .xfer_busy_o(xfer_busy_o)
    );

    // ====================
    // Pulse monitor: count, bit, and OR of receive and transmit clock levels at each pulse
    always @(posedge clock_i)
        for (int i = 0; i < 16; i++)
            if (rx_bit_valid_o[i] === 1'b1) begin
                pc[i]++;
                bt[i] = rx_bit_o[i];
                lv[i] = rxc[i] | txc[i];
            end

    // ====================
    // Tasks
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        chk($sformatf("register %h", a), reg_rdata_o, e);
        @(posedge clock_i);
    endtask : rd
    task automatic crd(input logic [9:0] a, input logic [15:0] e);
        cell_rd_addr_i <= a;
        cell_rd_en_i <= 1'b1;
        @(posedge clock_i);
        cell_rd_en_i <= 1'b0;
        @(negedge clock_i);
        chk($sformatf("cell memory %h", a), cell_rd_data_o, e);
        @(posedge clock_i);
    endtask : crd
    task automatic wait_idle;
        for (int i = 0; i < 100 && xfer_busy_o !== 1'b0; i++) @(posedge clock_i);
        chk("busy", {15'h0000, xfer_busy_o}, 16'h0000);
    endtask : wait_idle
    task automatic fe(input int l, input logic [15:0] c, input bit tx, input logic b, input int ec, input logic el);
        wr(12'h700 + 12'(l), c);
        pc = '{default: 0};
        trx_framer_model_inst.send_bit(l, tx, b);
        repeat (2) @(posedge clock_i);
        chk("pulses", 16'(pc.sum()), 16'(ec));
        chk("link pulses", 16'(pc[l]), 16'(ec));
        if (ec > 0) chk("bit and clock level", {14'h0000, bt[l], lv[l]}, {14'h0000, b, el});
    endtask : fe
    task automatic finish_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // ====================
    // Sequence
    initial begin
        #(3_000_000);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        rd(12'h700, 16'h0000);
        rd(12'h71F, 16'h0000);
        rd(12'h720, 16'h0000);
        rd(12'h741, 16'h0000);
        wr(12'h705, 16'hFFFF);
        rd(12'h705, 16'h07FF);
        wr(12'h735, 16'hFFFF);
        rd(12'h735, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            wr(12'h700 + 12'(i), 16'hF4A3);
            rd(12'h700 + 12'(i), 16'h04A3);
            wr(12'h710 + 12'(i), 16'hFFFF);
            wr(12'h720 + 12'(i), 16'(i) ^ 16'hC3A5);
            rd(12'h720 + 12'(i), 16'(i) ^ 16'hC3A5);
            chk("map low port", ts_map_low_o[16*i +: 16], 16'hFFFF);
            chk("map high port", ts_map_high_o[16*i +: 16], 16'(i) ^ 16'hC3A5);
        end
        wr(12'h741, 16'hFF36);
        rd(12'h741, 16'h0036);
        chk("tuning port", {8'h00, cell_sync_tuning_o}, 16'h0036);
        for (int i = 0; i < 9; i++) begin
            wr(12'h700 + 12'(rl[i]), 16'h0401 | {9'h000, rc[i], 5'h00});
            repeat (2) @(posedge clock_i);
            chk("rate fault", {15'h0000, rate_fault_o[rl[i]]}, {15'h0000, rf[i]});
            chk("rate port", {14'h0000, link_rate_o[2*rl[i] +: 2]}, {14'h0000, rc[i]});
        end
        rd(12'h743, 16'h4088);
        wr(12'hBE0, 16'hA5C3);
        wr(12'hBFF, 16'h5A3C);
        wr(12'h800, 16'h1234);
        rd(12'hBFF, 16'h5A3C);
        wr(12'h742, 16'h801F);
        wr(12'h742, 16'h8000);
        rd(12'h800, 16'h1234);
        wait_idle();
        rd(12'h742, 16'h001F);
        crd(10'h3E0, 16'hA5C3);
        crd(10'h3FF, 16'h5A3C);
        wr(12'h742, 16'h8000);
        wait_idle();
        crd(10'h000, 16'h1234);
        fe(0, 16'h04A1, 1'b0, 1'b1, 1, 1'b1);
        fe(0, 16'h04A3, 1'b0, 1'b0, 1, 1'b0);
        fe(0, 16'h0421, 1'b0, 1'b1, 0, 1'b0);
        fe(0, 16'h05A1, 1'b0, 1'b1, 0, 1'b0);
        fe(0, 16'h05A1, 1'b1, 1'b0, 1, 1'b1);
        fe(3, 16'h04A3, 1'b0, 1'b1, 1, 1'b0);
        finish_test();
    end
endmodule : trx_link_bank_tb
